// >>> hdl/sdb_pair_buf.sv
// two-entry valid/ready buffer holding read beat pairs
`timescale 1ns/1ps
module sdb_pair_buf #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = PTR_W + 1;

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    wire              push;
    wire              pop;

    assign in_ready_o  = (count != CNT_W'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = store[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= ptr_inc(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= ptr_inc(rd_ptr);
            end
            count <= count + CNT_W'(push) - CNT_W'(pop);
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            store[wr_ptr] <= in_data_i;
        end
    end
endmodule

// >>> hdl/sdb_pkg.sv
// shared constants, types and helpers for the burst-of-two ddr sram core
package sdb_pkg;

    // ------------------------------------------------------------------
    // array shape
    // ------------------------------------------------------------------
    localparam int DATA_W     = 18;
    localparam int LANE_W     = 9;
    localparam int NYB_LANE_W = 4;
    localparam int LANES      = 2;
    localparam int ADDR_W     = 4;
    localparam int BEATS      = 2;
    // lane width used for write masking; NYB_LANE_W selects the 8-bit variant
    localparam int WR_LANE_W  = LANE_W;

    // ------------------------------------------------------------------
    // counts and reset values
    // ------------------------------------------------------------------
    localparam int                  LOCK_CYCLES    = 1024;
    localparam int                  LOCK_CNT_W     = 11;
    localparam int                  ZQ_EVAL_CYCLES = 32;
    localparam int                  ZQ_CNT_W       = 6;
    localparam int                  IMP_CODE_W     = 4;
    localparam logic [IMP_CODE_W-1:0] IMP_CODE_RST = 4'h8;
    localparam logic [IMP_CODE_W-1:0] IMP_CODE_MAX = 4'hF;
    localparam logic [IMP_CODE_W-1:0] IMP_CODE_MIN = 4'h0;

    // ------------------------------------------------------------------
    // state types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LCH_WAIT_K      = 2'b00,
        LCH_WAIT_FIRST  = 2'b01,
        LCH_WAIT_KN     = 2'b10,
        LCH_WAIT_SECOND = 2'b11
    } sdb_launch_t;

    typedef enum logic [0:0] {
        WR_IDLE  = 1'b0,
        WR_BEAT2 = 1'b1
    } sdb_wr_t;

    // ------------------------------------------------------------------
    // lane-masked merge of a new word over an old one
    // ------------------------------------------------------------------
    function automatic logic [DATA_W-1:0] mask_merge(
        input logic [DATA_W-1:0] old_word,
        input logic [DATA_W-1:0] new_word,
        input logic [LANES-1:0]  mask_n,
        input int                lane_w
    );
        logic [DATA_W-1:0] res;
        res = old_word;
        for (int i = 0; i < DATA_W; i++) begin
            if ((i / lane_w) < LANES) begin
                if (!mask_n[i / lane_w]) begin
                    res[i] = new_word[i];
                end
            end
        end
        return res;
    endfunction

endpackage

// >>> hdl/sdb_sram_core.sv
// separate-io double-data-rate burst-of-two sram core, pins sampled on the system clock
`timescale 1ns/1ps
module sdb_sram_core (
    // system clock and reset
    input  wire logic                              clk_sys_i,
    input  wire logic                              rst_b_i,
    // memory interface clocks
    input  wire logic                              input_clock_i,
    input  wire logic                              input_clock_n_i,
    input  wire logic                              output_clock_i,
    input  wire logic                              output_clock_n_i,
    // command, address and write data
    input  wire logic                              read_enable_n_i,
    input  wire logic                              write_enable_n_i,
    input  wire logic [sdb_pkg::ADDR_W-1:0]        sync_address_i,
    input  wire logic [sdb_pkg::DATA_W-1:0]        data_in_i,
    input  wire logic [sdb_pkg::LANES-1:0]         byte_write_n_i,
    // loop control and impedance comparator
    input  wire logic                              dll_disable_n_i,
    input  wire logic                              impedance_ref_pin_i,
    // read data
    output logic [sdb_pkg::DATA_W-1:0]             data_out_o,
    output logic                                   data_out_oe_o,
    // status
    output logic                                   read_data_undefined_o,
    output logic                                   dll_locked_o,
    output logic [sdb_pkg::IMP_CODE_W-1:0]         pull_down_code_o,
    output logic [sdb_pkg::IMP_CODE_W-1:0]         pull_up_code_o
);
    import sdb_pkg::*;

    localparam int PIN_W = 8 + ADDR_W + DATA_W + LANES;
    localparam int PAIR_W = BEATS * DATA_W;

    // ------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_sync;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    wire  [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_s;
    logic [3:0]       clk_prev;

    assign pin_raw = {input_clock_i, input_clock_n_i, output_clock_i, output_clock_n_i,
                      read_enable_n_i, write_enable_n_i, dll_disable_n_i, impedance_ref_pin_i,
                      sync_address_i, data_in_i, byte_write_n_i};

    // pins are idle high except the data buses; resetting to ones avoids false edges
    always_ff @(posedge clk_sys_i or negedge rst_sync) begin
        if (!rst_sync) begin
            pin_meta <= '1;
            pin_s    <= '1;
            clk_prev <= 4'hF;
        end else begin
            pin_meta <= pin_raw;
            pin_s    <= pin_meta;
            clk_prev <= pin_s[PIN_W-1 -: 4];
        end
    end

    wire              k_s     = pin_s[PIN_W-1];
    wire              kn_s    = pin_s[PIN_W-2];
    wire              c_s     = pin_s[PIN_W-3];
    wire              cn_s    = pin_s[PIN_W-4];
    wire              ren_s   = pin_s[PIN_W-5];
    wire              wen_s   = pin_s[PIN_W-6];
    wire              dlln_s  = pin_s[PIN_W-7];
    wire              zq_s    = pin_s[PIN_W-8];
    wire [ADDR_W-1:0] addr_s  = pin_s[LANES+DATA_W +: ADDR_W];
    wire [DATA_W-1:0] din_s   = pin_s[LANES +: DATA_W];
    wire [LANES-1:0]  bwn_s   = pin_s[0 +: LANES];

    // ------------------------------------------------------------------
    // edge detection and output clock selection
    // ------------------------------------------------------------------
    wire k_rise  = k_s & ~clk_prev[3];
    wire kn_rise = kn_s & ~clk_prev[2];
    wire c_rise  = c_s & ~clk_prev[1];
    wire cn_rise = cn_s & ~clk_prev[0];
    // complementary output clocks are never both high unless tied off
    wire c_tied       = c_s & cn_s & clk_prev[1] & clk_prev[0];
    wire first_edge   = c_tied ? kn_rise : cn_rise;
    wire second_edge  = c_tied ? k_rise : c_rise;

    // ------------------------------------------------------------------
    // write port
    // ------------------------------------------------------------------
    sdb_wr_t          wr_state;
    logic [DATA_W-1:0] wd0;
    logic [LANES-1:0]  wm0;
    logic [DATA_W-1:0] mem [2**(ADDR_W+1)];

    wire wr_start  = k_rise & ~wen_s & (wr_state == WR_IDLE);
    wire wr_commit = kn_rise & (wr_state == WR_BEAT2);
    wire [ADDR_W:0] wr_idx0 = {addr_s, 1'b0};
    wire [ADDR_W:0] wr_idx1 = {addr_s, 1'b1};
    wire [DATA_W-1:0] wr_new0 = mask_merge(mem[wr_idx0], wd0, wm0, WR_LANE_W);
    wire [DATA_W-1:0] wr_new1 = mask_merge(mem[wr_idx1], din_s, bwn_s, WR_LANE_W);

    always_ff @(posedge clk_sys_i or negedge rst_sync) begin
        if (!rst_sync) begin
            wr_state <= WR_IDLE;
            wd0      <= '0;
            wm0      <= '1;
        end else begin
            unique case (wr_state)
                WR_IDLE: begin
                    if (wr_start) begin
                        wr_state <= WR_BEAT2;
                        wd0      <= din_s;
                        wm0      <= bwn_s;
                    end
                end
                WR_BEAT2: begin
                    if (kn_rise) begin
                        wr_state <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    // all-high masks leave both words as they were, so an abort needs no special path
    always_ff @(posedge clk_sys_i) begin
        if (wr_commit) begin
            mem[wr_idx0] <= wr_new0;
            mem[wr_idx1] <= wr_new1;
        end
    end

    // ------------------------------------------------------------------
    // read port: command, fetch with pass-through, buffered launch
    // ------------------------------------------------------------------
    logic              rd_pend;
    logic [ADDR_W-1:0] rd_addr;
    wire               buf_in_ready;
    wire               buf_out_valid;
    wire [PAIR_W-1:0]  buf_out_data;
    sdb_launch_t       lch_state;
    logic              kn_got;

    // a read is refused while both buffer entries are occupied
    wire rd_cmd   = k_rise & ~ren_s & buf_in_ready;
    wire push_vld = kn_rise & rd_pend;
    wire bypass   = wr_commit & (addr_s == rd_addr);
    wire [DATA_W-1:0] fetch0 = bypass ? wr_new0 : mem[{rd_addr, 1'b0}];
    wire [DATA_W-1:0] fetch1 = bypass ? wr_new1 : mem[{rd_addr, 1'b1}];
    wire buf_pop  = (lch_state == LCH_WAIT_SECOND) & second_edge;

    always_ff @(posedge clk_sys_i or negedge rst_sync) begin
        if (!rst_sync) begin
            rd_pend <= 1'b0;
            rd_addr <= '0;
        end else begin
            if (rd_cmd) begin
                rd_pend <= 1'b1;
                rd_addr <= addr_s;
            end else if (kn_rise) begin
                rd_pend <= 1'b0;
            end
        end
    end

    sdb_pair_buf #(
        .WIDTH (PAIR_W),
        .DEPTH (2)
    ) u_pair_buf (
        .clk_i       (clk_sys_i),
        .rst_b_i     (rst_sync),
        .in_valid_i  (push_vld),
        .in_ready_o  (buf_in_ready),
        .in_data_i   ({fetch1, fetch0}),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_pop),
        .out_data_o  (buf_out_data)
    );

    always_ff @(posedge clk_sys_i or negedge rst_sync) begin
        if (!rst_sync) begin
            lch_state     <= LCH_WAIT_K;
            data_out_o    <= '0;
            data_out_oe_o <= 1'b0;
            kn_got        <= 1'b0;
        end else begin
            // a lagging output_clock_n rises after input_clock_n; keep that edge so beat two is not a period late
            kn_got <= (lch_state == LCH_WAIT_FIRST) & (kn_got | kn_rise);
            unique case (lch_state)
                LCH_WAIT_K: begin
                    if (k_rise && buf_out_valid) begin
                        lch_state <= LCH_WAIT_FIRST;
                    end else if (first_edge) begin
                        data_out_oe_o <= 1'b0;
                    end
                end
                LCH_WAIT_FIRST: begin
                    if (first_edge) begin
                        data_out_o    <= buf_out_data[DATA_W-1:0];
                        data_out_oe_o <= 1'b1;
                        lch_state     <= (c_tied || kn_got || kn_rise) ? LCH_WAIT_SECOND : LCH_WAIT_KN;
                    end
                end
                LCH_WAIT_KN: begin
                    if (kn_rise) begin
                        lch_state <= LCH_WAIT_SECOND;
                    end
                end
                LCH_WAIT_SECOND: begin
                    if (second_edge) begin
                        data_out_o <= buf_out_data[PAIR_W-1:DATA_W];
                        // tied mode: this K rise is already the start of the next queued read
                        lch_state  <= (c_tied && !buf_in_ready) ? LCH_WAIT_FIRST : LCH_WAIT_K;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // delay-locked loop status
    // ------------------------------------------------------------------
    logic [LOCK_CNT_W-1:0] lock_cnt;

    always_ff @(posedge clk_sys_i or negedge rst_sync) begin
        if (!rst_sync) begin
            lock_cnt     <= '0;
            dll_locked_o <= 1'b0;
        end else if (!dlln_s) begin
            lock_cnt     <= '0;
            dll_locked_o <= 1'b0;
        end else if (k_rise && !dll_locked_o) begin
            lock_cnt     <= lock_cnt + 1'b1;
            dll_locked_o <= (lock_cnt == LOCK_CNT_W'(LOCK_CYCLES - 1));
        end
    end

    assign read_data_undefined_o = ~dll_locked_o;

    // ------------------------------------------------------------------
    // output impedance calibration
    // ------------------------------------------------------------------
    logic [ZQ_CNT_W-1:0] zq_cnt;
    logic                pd_pend;
    logic                pu_pend;
    logic                step_up;

    wire zq_eval  = (zq_cnt == ZQ_CNT_W'(ZQ_EVAL_CYCLES - 1));
    wire pd_apply = pd_pend & (~data_out_oe_o | data_out_o[0]);
    wire pu_apply = pu_pend & (~data_out_oe_o | ~data_out_o[0]);

    function automatic logic [IMP_CODE_W-1:0] imp_step(input logic [IMP_CODE_W-1:0] code,
                                                       input logic                  up);
        if (up) begin
            return (code == IMP_CODE_MAX) ? code : code + 1'b1;
        end
        return (code == IMP_CODE_MIN) ? code : code - 1'b1;
    endfunction

    // a new evaluation wins over a pending clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_sync) begin
        if (!rst_sync) begin
            zq_cnt           <= '0;
            pd_pend          <= 1'b0;
            pu_pend          <= 1'b0;
            step_up          <= 1'b0;
            pull_down_code_o <= IMP_CODE_RST;
            pull_up_code_o   <= IMP_CODE_RST;
        end else begin
            zq_cnt  <= zq_eval ? '0 : zq_cnt + 1'b1;
            pd_pend <= zq_eval | (pd_pend & ~pd_apply);
            pu_pend <= zq_eval | (pu_pend & ~pu_apply);
            if (zq_eval) begin
                step_up <= zq_s;
            end
            if (pd_apply) begin
                pull_down_code_o <= imp_step(pull_down_code_o, step_up);
            end
            if (pu_apply) begin
                pull_up_code_o <= imp_step(pull_up_code_o, step_up);
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions and coverage
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_sync);

    chk_read_accept: assert property (rd_cmd |=> rd_pend && rd_addr == $past(addr_s))
        else $error("read command not captured");
    chk_first_beat: assert property ((lch_state == LCH_WAIT_FIRST && first_edge)
        |=> data_out_oe_o && data_out_o == $past(buf_out_data[DATA_W-1:0]))
        else $error("first read beat not launched");
    chk_deselect_hiz: assert property ((lch_state == LCH_WAIT_K && first_edge && !(k_rise && buf_out_valid))
        |=> !data_out_oe_o)
        else $error("outputs driven in deselect slot");
    chk_write_capture: assert property (wr_start |=> wr_state == WR_BEAT2 && wd0 == $past(din_s)
        && wm0 == $past(bwn_s))
        else $error("first write beat not captured");
    chk_write_deselect: assert property ((k_rise && wen_s && wr_state == WR_IDLE) |=> wr_state == WR_IDLE)
        else $error("write started while deselected");
    chk_full_deselect: assert property ((k_rise && ren_s && wen_s && !rd_pend && wr_state == WR_IDLE)
        |=> !rd_pend && wr_state == WR_IDLE)
        else $error("activity while fully deselected");
    chk_write_hold: assert property ((wr_state == WR_BEAT2 && !kn_rise) |=> wr_state == WR_BEAT2)
        else $error("write transfer cut short");
    chk_abort_write: assert property ((wr_commit && (&wm0) && (&bwn_s))
        |=> mem[$past(wr_idx0)] == $past(mem[wr_idx0]) && mem[$past(wr_idx1)] == $past(mem[wr_idx1]))
        else $error("aborted write changed memory");
    chk_pass_thru: assert property ((push_vld && wr_commit && addr_s == rd_addr && wm0 == '0 && bwn_s == '0)
        |-> fetch0 == wd0 && fetch1 == din_s)
        else $error("pass-through returned stale data");
    chk_lock_count: assert property ($rose(dll_locked_o) |-> $past(lock_cnt) == LOCK_CNT_W'(LOCK_CYCLES - 1)
        && $past(dlln_s))
        else $error("lock flagged at wrong count");
    chk_imp_gate: assert property ((pull_down_code_o != $past(pull_down_code_o))
        |-> $past(!data_out_oe_o || data_out_o[0]))
        else $error("pull-down updated while driving zero");
    chk_imp_single: assert property (zq_eval |=> ##[1:40] !pd_pend || pd_apply)
        else $error("impedance update stuck");

    cov_read_pair:   cover property (buf_pop);
    cov_write:       cover property (wr_commit && !(&wm0));
    cov_pass_thru:   cover property (push_vld && bypass);
    cov_tied_launch: cover property (c_tied && lch_state == LCH_WAIT_FIRST && first_edge);
endmodule

// >>> testbench/sdb_ctrl_model.sv
// memory controller model: input clocks, output clocks and tied output mode
`timescale 1ns/1ps
module sdb_ctrl_model (
    // system clock and control
    input  wire logic  clk_sys_i,
    input  wire logic  run_i,
    input  wire logic  tied_i,
    // clock pins and phase
    output logic       input_clock_o,
    output logic       input_clock_n_o,
    output logic       output_clock_o,
    output logic       output_clock_n_o,
    output logic [2:0] phase_o
);
    // ------------------------------------------------------------------
    // eight system cycles per input clock period
    // ------------------------------------------------------------------
    // parked at the last phase until run, so the first step is an input_clock rise
    always @(negedge clk_sys_i) begin
        if (!run_i) begin
            phase_o <= 3'h7;
        end else begin
            phase_o <= phase_o + 3'h1;
        end
    end
    // one fixed frequency throughout; the loop is enabled only after the clocks run
    // clocks stand low until run, so they are stable before the loop is enabled
    assign input_clock_o    = run_i && (phase_o < 3'h4);
    assign input_clock_n_o  = run_i && (phase_o >= 3'h4);
    // output clocks lag one phase; tied mode holds both high
    assign output_clock_o   = tied_i || (run_i && phase_o >= 3'h1 && phase_o <= 3'h4);
    assign output_clock_n_o = tied_i || (run_i && (phase_o >= 3'h5 || phase_o == 3'h0));
endmodule

// >>> testbench/sdb_sram_core_bench.sv
// self-checking bench for the burst-of-two sram core
`timescale 1ns/1ps
module sdb_sram_core_bench;
    import sdb_pkg::*;
    logic clk_sys_i, rst_b_i, ren_n, wen_n, dll_n, zq, run, tied, kc, kcn, oc, ocn, oe, undef, lock;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din, dout;
    logic [LANES-1:0] bw_n;
    logic [IMP_CODE_W-1:0] pd, pu;
    logic [2:0] ph;
    logic [DATA_W-1:0] mem [0:31];
    int bad_count, num_checks;
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    sdb_ctrl_model u_ctrl (.clk_sys_i(clk_sys_i), .run_i(run), .tied_i(tied), .input_clock_o(kc),
        .input_clock_n_o(kcn), .output_clock_o(oc), .output_clock_n_o(ocn), .phase_o(ph));
    sdb_sram_core u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .input_clock_i(kc), .input_clock_n_i(kcn),
        .output_clock_i(oc), .output_clock_n_i(ocn), .read_enable_n_i(ren_n), .write_enable_n_i(wen_n),
        .sync_address_i(addr), .data_in_i(din), .byte_write_n_i(bw_n), .dll_disable_n_i(dll_n),
        .impedance_ref_pin_i(zq), .data_out_o(dout), .data_out_oe_o(oe), .read_data_undefined_o(undef),
        .dll_locked_o(lock), .pull_down_code_o(pd), .pull_up_code_o(pu));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n, input logic [1:0] m);
        logic [DATA_W-1:0] keep;
        keep = {{LANE_W{m[1]}}, {LANE_W{m[0]}}};
        return (o & keep) | (n & ~keep);
    endfunction
    // phase is sampled at the negedge where the model moves it on
    task wait_ph(input logic [2:0] p);
        int i;
        i = 0;
        @(negedge clk_sys_i);
        while (ph !== p && i < 20) begin
            @(negedge clk_sys_i);
            i++;
        end
        if (ph !== p) begin
            bad_count++;
            $display("FAIL phase wait expected %0d seen %0d", p, ph);
            print_verdict();
        end
    endtask
    task cmd(input logic r, w, input logic [3:0] a, input logic [17:0] d0, d1, input logic [1:0] m0, m1);
        wait_ph(3'h7);
        ren_n <= ~r;
        wen_n <= ~w;
        addr <= a;
        din <= d0;
        bw_n <= m0;
        wait_ph(3'h3);
        ren_n <= 1'b1;
        wen_n <= 1'b1;
        din <= d1;
        bw_n <= m1;
        if (w) mem[{a, 1'b0}] = merge(mem[{a, 1'b0}], d0, m0);
        if (w) mem[{a, 1'b1}] = merge(mem[{a, 1'b1}], d1, m1);
        // released lines show the inverse, never the last value
        wait_ph(3'h6);
        addr <= ~a;
        din <= ~d1;
        bw_n <= ~m1;
    endtask
    task rdchk(input logic [3:0] a);
        int i;
        i = 0;
        while (oe !== 1'b1 && i < 40) begin
            @(negedge clk_sys_i);
            i++;
        end
        if (oe !== 1'b1) begin
            bad_count++;
            $display("FAIL read wait expected 1 seen 0");
            print_verdict();
        end
        chk("beat0", mem[{a, 1'b0}], dout);
        repeat (4) @(negedge clk_sys_i);
        chk("beat1", mem[{a, 1'b1}], dout);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_lock;
        chk("locked off", 1'b0, lock);
        chk("undefined", 1'b1, undef);
        dll_n <= 1'b1;
        repeat (1000) wait_ph(3'h7);
        chk("locked early", 1'b0, lock);
        repeat (30) wait_ph(3'h7);
        chk("locked", 1'b1, lock);
        chk("defined", 1'b0, undef);
        chk("pull down code", IMP_CODE_MAX, pd);
        chk("pull up code", IMP_CODE_MAX, pu);
        dll_n <= 1'b0;
        repeat (2) wait_ph(3'h7);
        chk("locked cleared", 1'b0, lock);
        chk("undefined again", 1'b1, undef);
        dll_n <= 1'b1;
        $display("test lock done");
    endtask
    task t_mask;
        cmd(1'b0, 1'b1, 4'h5, 18'h15555, 18'h2AAAA, 2'b00, 2'b00);
        cmd(1'b0, 1'b1, 4'h5, 18'h3FFFF, 18'h3FFFF, 2'b10, 2'b01);
        cmd(1'b1, 1'b0, 4'h5, 18'h0, 18'h0, 2'b00, 2'b00);
        rdchk(4'h5);
        cmd(1'b0, 1'b1, 4'h5, 18'h0, 18'h0, 2'b11, 2'b11);
        cmd(1'b1, 1'b0, 4'h5, 18'h0, 18'h0, 2'b00, 2'b00);
        rdchk(4'h5);
        $display("test mask done");
    endtask
    task t_pass;
        cmd(1'b1, 1'b1, 4'h7, 18'h0A5C3, 18'h35A3C, 2'b00, 2'b00);
        rdchk(4'h7);
        $display("test pass done");
    endtask
    task t_desel;
        cmd(1'b0, 1'b0, 4'h5, 18'h0, 18'h0, 2'b00, 2'b00);
        repeat (24) begin
            @(negedge clk_sys_i);
            chk("oe deselect", 1'b0, oe);
        end
        cmd(1'b1, 1'b0, 4'h5, 18'h0, 18'h0, 2'b00, 2'b00);
        rdchk(4'h5);
        $display("test deselect done");
    endtask
    task t_tied;
        tied <= 1'b1;
        repeat (8) @(negedge clk_sys_i);
        cmd(1'b1, 1'b0, 4'h7, 18'h0, 18'h0, 2'b00, 2'b00);
        rdchk(4'h7);
        tied <= 1'b0;
        $display("test tied done");
    endtask
    initial begin
        {ren_n, wen_n, addr, din, bw_n} = '1;
        {rst_b_i, dll_n, run, tied, bad_count, num_checks} = '0;
        zq = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        run = 1'b1;
        t_lock();
        t_mask();
        t_pass();
        t_desel();
        t_tied();
        print_verdict();
    end
endmodule
